//--- testbench/dscp_pins_model.sv
// Outside circuitry: resolves the general I/O wires and flags when
// outside logic may use the released bus. Undriven wires take the outside level.
`timescale 1ns/10ps
module dscp_pins_model (
	// Device pins.
	input wire logic bus_release_ack_n,
	input wire logic bus_release_ack_oe,
	input wire logic ext_bus_oe,
	input wire logic [3:0] gp_io_pins_o,
	input wire logic [3:0] gp_io_pins_oe,
	// Outside drive and results.
	input wire logic [3:0] ext_level,
	output logic [3:0] gp_io_pins_i,
	output logic bus_owned
);
	// outside bus use
	// Outside masters may touch memory only while release is acknowledged.
	assign bus_owned = bus_release_ack_oe && !bus_release_ack_n && !ext_bus_oe;
	// Each wire carries whichever side enables it.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gp_io_pins_i[i] = gp_io_pins_oe[i] ? gp_io_pins_o[i] : ext_level[i];
		end
	end
endmodule : dscp_pins_model

//--- testbench/dscp_top_sva.sv
// Timing checker of the system-control pin block, bound to dscp_top.
// Assumes the bench holds each pin level for several cycles.
`timescale 1ns/10ps
module dscp_top_sva (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Pins and core controls.
	input wire logic output_float_n,
	input wire logic hold_int1_n,
	input wire logic nmi_n,
	input wire logic memory_map_select,
	input wire logic bus_release_ack_n,
	input wire logic bus_release_ack_oe,
	input wire logic ext_flag_oe,
	input wire logic [3:0] gp_io_pins_oe,
	input wire logic ext_bus_oe,
	input wire logic cpu_run,
	input wire logic [15:0] fetch_addr,
	input wire logic flash_map,
	input wire logic nmi_trap
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [4:0] run_cnt;
	logic run_seen;
	// Counts restart edges up to the first run only, so holds cannot skew it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_cnt <= 5'h00;
			run_seen <= 1'b0;
		end else if (!run_seen) begin
			run_cnt <= cpu_run ? run_cnt : run_cnt + 5'h01;
			run_seen <= cpu_run;
		end
	end
	chk_float_off: assert property (!output_float_n [*4] |->
		!bus_release_ack_oe && !ext_flag_oe && gp_io_pins_oe == 4'h0)
		else $error("outputs driven while floating");
	chk_ack_bus: assert property (!bus_release_ack_n |-> !ext_bus_oe)
		else $error("bus driven during acknowledge");
	chk_hold_cause: assert property ($fell(bus_release_ack_n) |->
		!hold_int1_n && $past(hold_int1_n, 2) == 1'b0)
		else $error("acknowledge without hold request");
	chk_run_delay: assert property ($rose(cpu_run) && !run_seen |->
		run_cnt == 5'h11) else $error("restart length wrong");
	chk_fetch_zero: assert property (cpu_run |-> fetch_addr == 16'h0000)
		else $error("fetch address not zero");
	chk_nmi_pulse: assert property (nmi_trap |->
		$past(nmi_n, 2) == 1'b0 ##1 !nmi_trap) else $error("trap pulse bad");
	chk_map_keep: assert property ($past(cpu_run) |-> $stable(flash_map))
		else $error("map changed after restart");
	chk_map_sel: assert property ($rose(cpu_run) && !run_seen |->
		flash_map == !memory_map_select) else $error("map select wrong");
	chk_io_inputs: assert property (!cpu_run && !run_seen |->
		gp_io_pins_oe == 4'h0) else $error("io driven in restart");
	cover property ($fell(bus_release_ack_n));
	cover property (nmi_trap);
	cover property ($rose(cpu_run));
endmodule : dscp_top_sva
bind dscp_top dscp_top_sva chk (.hclk, .hresetn, .output_float_n,
	.hold_int1_n, .nmi_n, .memory_map_select, .bus_release_ack_n,
	.bus_release_ack_oe, .ext_flag_oe, .gp_io_pins_oe, .ext_bus_oe,
	.cpu_run, .fetch_addr, .flash_map, .nmi_trap);

//--- testbench/tb_top.sv
// Bench of the system-control pin block, driven over AHB-Lite.
// Assumes no fixed answer latency; every bus wait is open ended.
`timescale 1ns/10ps
`include "dscp_consts.svh"
module tb_top;
	import dscp_pkg::*;
	logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	dscp_word_t hrdata, rd;
	logic flt_n = 1'b1, hold_n = 1'b1, br_in = 1'b1, nmi_n = 1'b1, strap = 1'b1;
	logic fsync = 1'b0, ack_n, ack_oe, flag, flag_oe, bus_oe, run, fmap, trap;
	logic int1, irq, owned;
	logic [3:0] io_i, io_o, io_oe, ext_lvl = 4'h9;
	logic [15:0] faddr;
	int mismatches = 0, total_checks = 0, cycles = 0;
	int int1_pulses = 0, trap_pulses = 0;
	dscp_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.output_float_n(flt_n), .hold_int1_n(hold_n),
		.branch_test_input(br_in), .nmi_n, .memory_map_select(strap),
		.gp_io_pins_i(io_i), .serial_fsync(fsync),
		.bus_release_ack_n(ack_n), .bus_release_ack_oe(ack_oe),
		.ext_flag_out(flag), .ext_flag_oe(flag_oe), .gp_io_pins_o(io_o),
		.gp_io_pins_oe(io_oe), .ext_bus_oe(bus_oe), .cpu_run(run),
		.fetch_addr(faddr), .flash_map(fmap), .nmi_trap(trap), .int1_req(int1),
		.irq);
	dscp_pins_model far (.bus_release_ack_n(ack_n), .bus_release_ack_oe(ack_oe),
		.ext_bus_oe(bus_oe), .gp_io_pins_o(io_o), .gp_io_pins_oe(io_oe),
		.ext_level(ext_lvl), .gp_io_pins_i(io_i), .bus_owned(owned));
	// Free running machine clock.
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	// Counts one-cycle pulses, which a sampled compare could miss.
	always @(posedge hclk) begin
		if (int1 === 1'b1) begin
			int1_pulses++;
		end
		if (trap === 1'b1) begin
			trap_pulses++;
		end
	end
	// Cuts a hang short; the run needs well under a thousand cycles.
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One single transfer; read data is taken at the end of the data phase.
	task automatic bus(input logic wr, input logic [7:0] a, input dscp_word_t d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask : tick
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	// Main sequence; pins change by non-blocking assignment after an edge.
	initial begin
		tick(3);
		hresetn <= 1'b1;
		tick(2);
		chk(io_oe, 4'h0);
		tick(15);
		chk(run, 1'b0);
		tick(1);
		chk({run, fmap, faddr}, 18'h20000);
		strap <= 1'b0;
		tick(4);
		bus(1'b0, `DSCP_PROC_MODE_OFS, 32'h0);
		chk(fmap, 1'b0);
		chk(rd, 32'h1);
		$display("restart test done");
		bus(1'b1, `DSCP_CTRL_OFS, 32'h1);
		tick(2);
		chk({flag_oe, flag}, 2'h3);
		bus(1'b1, `DSCP_UART_CTRL_OFS, 32'h3F);
		tick(2);
		chk({io_oe, io_o}, 8'hF3);
		bus(1'b1, `DSCP_UART_CTRL_OFS, 32'h0);
		tick(4);
		bus(1'b0, `DSCP_PIN_STAT_OFS, 32'h0);
		chk(rd[3:0], 4'h9);
		bus(1'b1, `DSCP_CTRL_OFS, 32'h4);
		fsync <= 1'b1;
		tick(3);
		chk({io_oe[0], io_o[0], flag}, 3'h6);
		fsync <= 1'b0;
		tick(2);
		chk(io_o[0], 1'b0);
		bus(1'b1, `DSCP_CTRL_OFS, 32'h1);
		bus(1'b1, `DSCP_UART_CTRL_OFS, 32'h0F);
		flt_n <= 1'b0;
		tick(5);
		chk({ack_oe, flag_oe, io_oe}, 6'h00);
		flt_n <= 1'b1;
		tick(5);
		chk({ack_oe, flag_oe, io_oe}, 6'h3F);
		$display("pin test done");
		// Branch taken only while the test input is low.
		for (int i = 0; i < 2; i++) begin
			br_in <= i[0];
			tick(4);
			bus(1'b1, `DSCP_BRANCH_OFS, 32'h0);
			bus(1'b0, `DSCP_BRANCH_OFS, 32'h0);
			chk(rd[0], !i[0]);
		end
		bus(1'b1, `DSCP_CTRL_OFS, 32'h0);
		bus(1'b0, `DSCP_IRQ_STAT_OFS, 32'h0);
		hold_n <= 1'b0;
		tick(6);
		chk({ack_n, bus_oe, run, owned}, 4'h1);
		hold_n <= 1'b1;
		tick(6);
		chk({ack_n, bus_oe, run, owned}, 4'hE);
		bus(1'b1, `DSCP_CTRL_OFS, 32'h2);
		hold_n <= 1'b0;
		tick(6);
		chk(ack_n, 1'b1);
		hold_n <= 1'b1;
		tick(4);
		bus(1'b0, `DSCP_IRQ_STAT_OFS, 32'h0);
		chk(rd[3:1], 3'h7);
		chk(int1_pulses, 1);
		$display("hold test done");
		bus(1'b1, `DSCP_IRQ_MASK_OFS, 32'h0);
		nmi_n <= 1'b0;
		tick(5);
		chk(irq, 1'b0);
		bus(1'b0, `DSCP_IRQ_STAT_OFS, 32'h0);
		chk(rd[0], 1'b1);
		chk(trap_pulses, 1);
		nmi_n <= 1'b1;
		bus(1'b1, `DSCP_IRQ_MASK_OFS, 32'h1);
		bus(1'b0, `DSCP_IRQ_MASK_OFS, 32'h0);
		chk(rd, 32'h1);
		nmi_n <= 1'b0;
		tick(5);
		chk(irq, 1'b1);
		chk(trap_pulses, 2);
		bus(1'b0, `DSCP_IRQ_STAT_OFS, 32'h0);
		tick(3);
		chk(irq, 1'b0);
		bus(1'b1, 8'h40, 32'hFFFF);
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		chk(hresp, 1'b0);
		hresetn <= 1'b0;
		tick(1);
		chk(run, 1'b0);
		hresetn <= 1'b1;
		tick(20);
		chk({run, fmap, faddr}, 18'h30000);
		$display("interrupt test done");
		finish_test();
	end
endmodule : tb_top

//--- verilog/dscp_consts.svh
// Offsets, field positions, reset values and timing counts of the
// system-control pin block. Definitions only, no logic.
`ifndef DSCP_CONSTS_SVH
`define DSCP_CONSTS_SVH
// Register byte offsets on the bus.
`define DSCP_CTRL_OFS 8'h00
`define DSCP_UART_CTRL_OFS 8'h04
`define DSCP_PIN_STAT_OFS 8'h08
`define DSCP_PROC_MODE_OFS 8'h0C
`define DSCP_BRANCH_OFS 8'h10
`define DSCP_IRQ_STAT_OFS 8'h14
`define DSCP_IRQ_MASK_OFS 8'h18
// Control register fields.
`define DSCP_CTRL_FLAG 0
`define DSCP_CTRL_MODE 1
`define DSCP_CTRL_MCH 2
// Interrupt status fields.
`define DSCP_IRQ_NMI 0
`define DSCP_IRQ_HOLD_IN 1
`define DSCP_IRQ_HOLD_OUT 2
`define DSCP_IRQ_INT1 3
`define DSCP_IRQ_RUN 4
`define DSCP_IRQ_W 5
// Reset values.
`define DSCP_CTRL_RST 3'h0
`define DSCP_UART_CTRL_RST 8'h00
`define DSCP_PC_RST 16'h0000
// Restart wait after reset release, in machine cycles.
`define DSCP_RESTART_CYCLES 5'd16
`endif

//--- verilog/dscp_pkg.sv
// Types shared by the system-control pin block.
// Assumes the constants header is compiled alongside.
package dscp_pkg;
	typedef enum logic [2:0] {
		DSCP_RESTART = 3'b001,
		DSCP_RUN = 3'b010,
		DSCP_HOLD = 3'b100
	} dscp_state_e;
	typedef logic [31:0] dscp_word_t;
endpackage : dscp_pkg

//--- verilog/dscp_top.sv
// System-control pin logic of a 16-bit signal processor: bus release,
// flag output, branch test, general I/O, restart and map select.
// Assumes an AHB-Lite master on hclk and pins from outside the domain.
// Operation
// - Hold tristates bus, asserts release acknowledge
// - Float control tristates ack, flag, I/O
// - Flag output drives software latched level
// - Branch test taken only when input low
// - I/O pins reset as inputs, software set
// - Multichannel mode drives frame sync on io0
// - Reset stops execution, clears program counter
// - Fetch at address zero seventeen cycles later
// - Map select low maps flash, high external
// - Map select followed during restart wait into mode bit0
// - NMI traps regardless of masks
// - Mode bit zero makes shared pin hold
`timescale 1ns/10ps
`include "dscp_consts.svh"

module dscp_top (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output dscp_pkg::dscp_word_t hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pins from outside.
	input wire logic output_float_n,
	input wire logic hold_int1_n,
	input wire logic branch_test_input,
	input wire logic nmi_n,
	input wire logic memory_map_select,
	input wire logic [3:0] gp_io_pins_i,
	// Frame sync from the serial port, same clock.
	input wire logic serial_fsync,
	// Release acknowledge pin, active low.
	output logic bus_release_ack_n,
	output logic bus_release_ack_oe,
	// Flag pin.
	output logic ext_flag_out,
	output logic ext_flag_oe,
	// General I/O pins.
	output logic [3:0] gp_io_pins_o,
	output logic [3:0] gp_io_pins_oe,
	// Core-side controls.
	output logic ext_bus_oe,
	output logic cpu_run,
	output logic [15:0] fetch_addr,
	output logic flash_map,
	output logic nmi_trap,
	output logic int1_req,
	output logic irq
);
	import dscp_pkg::*;

	dscp_state_e state_reg;
	logic [4:0] cnt_reg;
	logic [2:0] ctrl_reg;
	logic [7:0] uart_ctrl_reg;
	logic proc_mode_status;
	logic branch_taken_reg;
	logic [`DSCP_IRQ_W-1:0] irq_stat_reg;
	logic [`DSCP_IRQ_W-1:0] irq_mask_reg;
	logic [`DSCP_IRQ_W-1:0] ev;
	logic [8:0] s1_reg;
	logic [8:0] s2_reg;
	logic nmi_d_reg;
	logic int1_d_reg;
	logic wr_reg;
	logic [7:0] wa_reg;
	logic acc;
	logic rd_clr;
	dscp_word_t rdata_next;

	// Two-stage synchronisers; only s2 is read by logic.
	// Pins are asynchronous to hclk; the first stage may go metastable,
	// so it gets a full cycle to settle before anything reads it.
	// synchronise pin inputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_reg <= 9'h1FF;
			s2_reg <= 9'h1FF;
		end else begin
			s1_reg <= {output_float_n, hold_int1_n, branch_test_input,
				nmi_n, memory_map_select, gp_io_pins_i};
			s2_reg <= s1_reg;
		end
	end

	// Synchronised pin levels, active high where the pin is active low, except branch_s, which keeps the pin level.
	logic float_s;
	logic hold_s;
	logic branch_s;
	logic nmi_s;
	logic mmap_s;
	logic [3:0] io_s;
	assign float_s = ~s2_reg[8];
	assign hold_s = ~s2_reg[7];
	assign branch_s = s2_reg[6];
	assign nmi_s = ~s2_reg[5];
	assign mmap_s = s2_reg[4];
	assign io_s = s2_reg[3:0];

	// Bus accept: a transfer is taken in its address phase.
	// hready is part of the accept so that a stall by another slave
	// on a shared bus can never make the block take an address twice.
	assign acc = hsel & htrans[1] & hready;
	assign rd_clr = acc & ~hwrite & (haddr == `DSCP_IRQ_STAT_OFS);

	// Address phase captured for the write data phase.
	// The address is caught every edge; only wr_reg says it matters.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg <= 1'b0;
			wa_reg <= 8'h00;
		end else begin
			wr_reg <= acc & hwrite;
			wa_reg <= haddr;
		end
	end

	// Read mux; answered in the data phase with no wait state.
	// Only the status register has a read side effect, see rd_clr.
	always_comb begin
		rdata_next = 32'h0000_0000;
		unique case (haddr)
			`DSCP_CTRL_OFS: rdata_next = {29'h0, ctrl_reg};
			`DSCP_UART_CTRL_OFS: rdata_next = {24'h0, uart_ctrl_reg};
			`DSCP_PIN_STAT_OFS: rdata_next = {22'h0, state_reg,
				nmi_s, branch_s, hold_s, io_s};
			`DSCP_PROC_MODE_OFS: rdata_next = {31'h0, proc_mode_status};
			`DSCP_BRANCH_OFS: rdata_next = {31'h0, branch_taken_reg};
			`DSCP_IRQ_STAT_OFS: rdata_next = {27'h0, irq_stat_reg};
			`DSCP_IRQ_MASK_OFS: rdata_next = {27'h0, irq_mask_reg};
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// Read data register; unmapped offsets read zero, always OKAY.
	// hreadyout never drops, since every register answers at once.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (acc && !hwrite) begin
				hrdata <= rdata_next;
			end
		end
	end

	// Write strobe of one register in its data phase. Shared by every
	// writable register so that all decode the address the same way.
	function automatic logic wr_hit(input logic we, input logic [7:0] wa,
		input logic [7:0] ofs);
		wr_hit = we && (wa == ofs);
	endfunction : wr_hit

	// Software control registers. Mode bit resets to hold use.
	// Unmapped writes fall through every decode and are dropped.
	// mode bit reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= `DSCP_CTRL_RST;
			uart_ctrl_reg <= `DSCP_UART_CTRL_RST;
			irq_mask_reg <= '0;
		end else begin
			if (wr_hit(wr_reg, wa_reg, `DSCP_CTRL_OFS)) begin
				ctrl_reg <= hwdata[2:0];
			end
			if (wr_hit(wr_reg, wa_reg, `DSCP_UART_CTRL_OFS)) begin
				uart_ctrl_reg <= hwdata[7:0];
			end
			if (wr_hit(wr_reg, wa_reg, `DSCP_IRQ_MASK_OFS)) begin
				irq_mask_reg <= hwdata[`DSCP_IRQ_W-1:0];
			end
		end
	end

	// A write to the branch register executes one branch test.
	// The level tested is the synchronised one, two edges old.
	// branch when low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			branch_taken_reg <= 1'b0;
		end else if (wr_hit(wr_reg, wa_reg, `DSCP_BRANCH_OFS)) begin
			branch_taken_reg <= ~branch_s;
		end
	end

	// Restart sequencer: wait, run, or hold the external bus.
	// The counter only moves during the wait and keeps its last value
	// afterwards; the next reset brings it back to zero. Hold is refused
	// during the wait because the bus is not yet in use.
	// stop and clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= DSCP_RESTART;
			cnt_reg <= 5'd0;
		end else begin
			unique case (state_reg)
				DSCP_RESTART: begin
					cnt_reg <= cnt_reg + 5'd1;
					if (cnt_reg == `DSCP_RESTART_CYCLES - 5'd1) begin
						state_reg <= DSCP_RUN;
					end
				end
				DSCP_RUN: begin
					if (hold_s && !ctrl_reg[`DSCP_CTRL_MODE]) begin
						state_reg <= DSCP_HOLD;
					end
				end
				DSCP_HOLD: begin
					if (!hold_s || ctrl_reg[`DSCP_CTRL_MODE]) begin
						state_reg <= DSCP_RUN;
					end
				end
				default: state_reg <= DSCP_RESTART;
			endcase
		end
	end

	// Map select is caught only while the restart wait runs, after
	// the pin has settled through the synchroniser.
	// A strap that moves during the wait is followed; the last value counts.
	// capture during restart wait
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			proc_mode_status <= 1'b0;
		end else if (state_reg == DSCP_RESTART) begin
			proc_mode_status <= mmap_s;
		end
	end

	// Edge detectors for NMI and the shared interrupt use.
	// Reset values match the idle synchronised levels: no false edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nmi_d_reg <= 1'b0;
			int1_d_reg <= 1'b0;
		end else begin
			nmi_d_reg <= nmi_s;
			int1_d_reg <= hold_s;
		end
	end

	// Events that set sticky status bits.
	always_comb begin
		ev = '0;
		ev[`DSCP_IRQ_NMI] = nmi_s & ~nmi_d_reg;
		ev[`DSCP_IRQ_HOLD_IN] = (state_reg == DSCP_RUN) & hold_s &
			~ctrl_reg[`DSCP_CTRL_MODE];
		ev[`DSCP_IRQ_HOLD_OUT] = (state_reg == DSCP_HOLD) &
			(~hold_s | ctrl_reg[`DSCP_CTRL_MODE]);
		ev[`DSCP_IRQ_INT1] = hold_s & ~int1_d_reg &
			ctrl_reg[`DSCP_CTRL_MODE];
		ev[`DSCP_IRQ_RUN] = (state_reg == DSCP_RESTART) &
			(cnt_reg == `DSCP_RESTART_CYCLES - 5'd1);
	end

	// Status clears on read; a new event in that cycle still sets.
	// Limitation: events repeating before a read are counted once only.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (rd_clr ? '0 : irq_stat_reg) | ev;
		end
	end

	// Core-side outputs, all registered.
	// irq lags the status by one cycle, the price of a registered pin.
	// fetch_addr stays at the reset value; the core counts from there.
	// unmaskable trap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nmi_trap <= 1'b0;
			int1_req <= 1'b0;
			irq <= 1'b0;
			cpu_run <= 1'b0;
			fetch_addr <= `DSCP_PC_RST;
			flash_map <= 1'b1;
			ext_bus_oe <= 1'b0;
		end else begin
			nmi_trap <= ev[`DSCP_IRQ_NMI];
			int1_req <= ev[`DSCP_IRQ_INT1];
			irq <= |(irq_stat_reg & irq_mask_reg);
			cpu_run <= (state_reg == DSCP_RUN);
			fetch_addr <= `DSCP_PC_RST;
			flash_map <= ~proc_mode_status;
			// Bus drivers off while held or floated.
			ext_bus_oe <= (state_reg == DSCP_RUN) & ~float_s;
		end
	end

	// Pin drivers. Float wins over every other source, since the
	// board may be driving these nets during test.
	// In multichannel mode the serial port owns io0, so its frame sync
	// overrides the direction bit that software set.
	// float tristates
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_release_ack_n <= 1'b1;
			bus_release_ack_oe <= 1'b0;
			ext_flag_out <= 1'b0;
			ext_flag_oe <= 1'b0;
			gp_io_pins_o <= 4'h0;
			gp_io_pins_oe <= 4'h0;
		end else begin
			bus_release_ack_n <= ~(state_reg == DSCP_HOLD);
			bus_release_ack_oe <= ~float_s;
			ext_flag_out <= ctrl_reg[`DSCP_CTRL_FLAG];
			ext_flag_oe <= ~float_s;
			gp_io_pins_o <= uart_ctrl_reg[7:4];
			gp_io_pins_oe <= float_s ? 4'h0 : uart_ctrl_reg[3:0];
			if (ctrl_reg[`DSCP_CTRL_MCH]) begin
				gp_io_pins_o[0] <= serial_fsync;
				gp_io_pins_oe[0] <= ~float_s;
			end
		end
	end

endmodule : dscp_top
